// ==== verilog/timer_pwm_pkg.sv ====
`default_nettype none
package timer_pwm_pkg;
   // Register bus, counter and prescaler widths, and the channel count.
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PRE_W = 7;
   localparam int unsigned NUM_CH = 2;

   // Register offsets, one byte register per address.
   localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
   localparam logic [3:0] ADDR_LIMIT_HIGH = 4'h3;
   localparam logic [3:0] ADDR_LIMIT_LOW = 4'h4;
   localparam logic [3:0] ADDR_CH_CTRL [0:1] = '{4'h5, 4'h8};
   localparam logic [3:0] ADDR_CH_VAL_HIGH [0:1] = '{4'h6, 4'h9};
   localparam logic [3:0] ADDR_CH_VAL_LOW [0:1] = '{4'h7, 4'hA};
   localparam logic [3:0] ADDR_OPTION = 4'hB;

   // Status and control field positions.
   localparam int unsigned SC_FLAG_BIT = 7;
   localparam int unsigned SC_IE_BIT = 6;
   localparam int unsigned SC_CENTER_BIT = 5;
   localparam int unsigned SC_CLKSEL_LSB = 3;
   localparam int unsigned SC_PS_LSB = 0;

   // Channel control field positions.
   localparam int unsigned CH_FLAG_BIT = 7;
   localparam int unsigned CH_IE_BIT = 6;
   localparam int unsigned CH_MODE_LSB = 4;
   localparam int unsigned CH_EDGE_LSB = 2;

   // Option register field positions.
   localparam int unsigned OPT_CH0_SRC_BIT = 0;
   localparam int unsigned OPT_PULLUP_LSB = 1;

   // Clock source codes.
   localparam logic [1:0] CLKSEL_OFF = 2'h0;
   localparam logic [1:0] CLKSEL_BUS = 2'h1;
   localparam logic [1:0] CLKSEL_XTAL = 2'h3;

   // Channel mode and edge or action codes.
   localparam logic [1:0] MODE_CAPTURE = 2'h0;
   localparam logic [1:0] MODE_COMPARE = 2'h1;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // Values after reset, and the counter's all-ones and zero values.
   localparam logic [6:0] SC_RESET = 7'h00;
   localparam logic [7:0] CH_CTRL_RESET = 8'h00;
   localparam logic [2:0] OPT_RESET = 3'h0;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [15:0] VAL_RESET = 16'h0000;
   localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // Crystal-derived clock rate against the system clock.
   localparam int unsigned SYS_CLK_FREQ_KHZ = 100000;
   localparam int unsigned XTAL_CLK_FREQ_KHZ = 500;
   localparam int unsigned XTAL_PERIOD_CYCLES = SYS_CLK_FREQ_KHZ / XTAL_CLK_FREQ_KHZ;
endpackage
`default_nettype wire

// ==== verilog/two_channel_timer_pwm.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_channel_timer_pwm
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_crystal_derived_clock,
   input wire logic i_slow_oscillator,
   input wire logic [1:0] i_chan_pin,
   output logic [1:0] o_chan_pin,
   output logic [1:0] o_chan_pin_oe_n,
   output logic [1:0] o_chan_pullup,
   input wire logic [1:0] i_gpio_data,
   input wire logic [1:0] i_gpio_dir,
   output logic o_wrap_irq,
   output logic [1:0] o_chan_irq
);

   // Mask of low prescaler bits that must all be one for a divided pulse.
   function automatic logic [6:0] prescale_mask(input logic [2:0] ps);
      logic [6:0] m;
      m = 7'h00;
      unique case (ps)
         3'h0: m = 7'h00;
         3'h1: m = 7'h01;
         3'h2: m = 7'h03;
         3'h3: m = 7'h07;
         3'h4: m = 7'h0F;
         3'h5: m = 7'h1F;
         3'h6: m = 7'h3F;
         3'h7: m = 7'h7F;
      endcase
      return m;
   endfunction

   // Replaces one byte of a 16-bit word.
   function automatic logic [15:0] set_byte(input logic [15:0] w, input logic hi,
                                            input logic [7:0] d);
      return hi ? {d, w[7:0]} : {w[15:8], d};
   endfunction

   // Read-then-write-zero clearing of a hardware flag; a new set always wins.
   function automatic logic [1:0] flag_step(input logic flag, input logic armed,
                                            input logic set_ev, input logic rd_hit,
                                            input logic wr_hit, input logic wbit);
      logic f;
      logic a;
      f = flag;
      a = armed;
      if (wr_hit)
      begin
         if (armed && !wbit)
         begin
            f = 1'b0;
         end
         a = 1'b0;
      end
      if (rd_hit && flag)
      begin
         a = 1'b1;
      end
      if (set_ev)
      begin
         f = 1'b1;
         a = 1'b0;
      end
      return {f, a};
   endfunction

   logic [6:0] sc_reg, sc_next;
   logic wrap_flag_reg, wrap_flag_next;
   logic wrap_arm_reg, wrap_arm_next;
   logic [15:0] cnt_reg, cnt_next;
   logic down_reg, down_next;
   logic [6:0] pre_reg, pre_next;
   logic [15:0] limit_reg, limit_next;
   logic lim_pend_hi_reg, lim_pend_hi_next;
   logic lim_pend_lo_reg, lim_pend_lo_next;
   logic [15:0] latch_reg, latch_next;
   logic latched_reg, latched_next;
   logic latch_hi_first_reg, latch_hi_first_next;
   logic [2:0] opt_reg, opt_next;
   logic [7:0] ch_ctrl_reg [0:1];
   logic [7:0] ch_ctrl_next [0:1];
   logic [15:0] ch_val_reg [0:1];
   logic [15:0] ch_val_next [0:1];
   logic [15:0] ch_buf_reg [0:1];
   logic [15:0] ch_buf_next [0:1];
   logic [1:0] ch_flag_reg, ch_flag_next;
   logic [1:0] ch_arm_reg, ch_arm_next;
   logic [1:0] ch_out_reg, ch_out_next;
   logic [1:0] cap_prev_reg, cap_prev_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [1:0] pin_reg, pin_next;
   logic [1:0] oe_n_reg, oe_n_next;
   logic [1:0] pullup_reg, pullup_next;
   logic wrap_irq_reg, wrap_irq_next;
   logic [1:0] ch_irq_reg, ch_irq_next;
   logic xtal_s1_reg, xtal_s2_reg, xtal_s3_reg;
   logic slow_s1_reg, slow_s2_reg;
   logic [1:0] pin_s1_reg, pin_s2_reg;
   logic center;
   logic [1:0] clksel;
   logic src_tick;
   logic ptick;
   logic [15:0] top;
   logic wrap_ev;
   logic cnt_wr;
   logic sc_rd;
   logic sc_wr;

   assign center = sc_reg[timer_pwm_pkg::SC_CENTER_BIT];
   assign clksel = sc_reg[timer_pwm_pkg::SC_CLKSEL_LSB +: 2];
   assign cnt_wr = i_wr && (i_addr == timer_pwm_pkg::ADDR_COUNT_HIGH ||
                            i_addr == timer_pwm_pkg::ADDR_COUNT_LOW);
   assign sc_rd = i_rd && i_addr == timer_pwm_pkg::ADDR_STATUS_CTRL;
   assign sc_wr = i_wr && i_addr == timer_pwm_pkg::ADDR_STATUS_CTRL;

   // Outside signals pass two flip-flops; the crystal clock gets a third for edge finding.
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         xtal_s1_reg <= 1'b0;
         xtal_s2_reg <= 1'b0;
         xtal_s3_reg <= 1'b0;
         slow_s1_reg <= 1'b0;
         slow_s2_reg <= 1'b0;
         pin_s1_reg <= 2'h0;
         pin_s2_reg <= 2'h0;
      end
      else
      begin
         xtal_s1_reg <= i_crystal_derived_clock;
         xtal_s2_reg <= xtal_s1_reg;
         xtal_s3_reg <= xtal_s2_reg;
         slow_s1_reg <= i_slow_oscillator;
         slow_s2_reg <= slow_s1_reg;
         pin_s1_reg <= i_chan_pin;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Clock source, prescaler and shared counter.
   always_comb
   begin
      src_tick = 1'b0;
      unique case (clksel)
         timer_pwm_pkg::CLKSEL_BUS: src_tick = 1'b1;
         timer_pwm_pkg::CLKSEL_XTAL: src_tick = xtal_s2_reg & ~xtal_s3_reg;
         default: src_tick = 1'b0;
      endcase
      ptick = src_tick && ((pre_reg & prescale_mask(sc_reg[2:0])) ==
                           prescale_mask(sc_reg[2:0]));
      pre_next = pre_reg;
      if (clksel == timer_pwm_pkg::CLKSEL_OFF)
      begin
         pre_next = 7'h00;
      end
      else if (src_tick)
      begin
         pre_next = pre_reg + 7'h01;
      end
      // Limits of all zeros or all ones count the full 16-bit range.
      top = (limit_reg == timer_pwm_pkg::CNT_ZERO || limit_reg == timer_pwm_pkg::CNT_ALL_ONES)
            ? timer_pwm_pkg::CNT_ALL_ONES : limit_reg;
      cnt_next = cnt_reg;
      down_next = down_reg;
      wrap_ev = 1'b0;
      if (cnt_wr)
      begin
         cnt_next = timer_pwm_pkg::CNT_RESET;
         down_next = 1'b0;
         pre_next = 7'h00;
      end
      else if (ptick && center)
      begin
         if (!down_reg && cnt_reg == top)
         begin
            down_next = 1'b1;
            cnt_next = cnt_reg - 16'h0001;
            wrap_ev = 1'b1;
         end
         else if (down_reg && cnt_reg == timer_pwm_pkg::CNT_ZERO)
         begin
            down_next = 1'b0;
            cnt_next = cnt_reg + 16'h0001;
         end
         else
         begin
            cnt_next = down_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
         end
      end
      else if (ptick)
      begin
         down_next = 1'b0;
         if (cnt_reg == top)
         begin
            cnt_next = timer_pwm_pkg::CNT_ZERO;
            wrap_ev = 1'b1;
         end
         else
         begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
   end

   // Register file, wrap flag, coherent count reads and limit writes.
   always_comb
   begin
      sc_next = sc_reg;
      opt_next = opt_reg;
      limit_next = limit_reg;
      lim_pend_hi_next = lim_pend_hi_reg;
      lim_pend_lo_next = lim_pend_lo_reg;
      latch_next = latch_reg;
      latched_next = latched_reg;
      latch_hi_first_next = latch_hi_first_reg;
      rdata_next = 8'h00;
      if (sc_wr)
      begin
         sc_next = i_wdata[6:0];
         latched_next = 1'b0;
      end
      if (i_wr && i_addr == timer_pwm_pkg::ADDR_OPTION)
      begin
         opt_next = i_wdata[2:0];
      end
      if (cnt_wr)
      begin
         latched_next = 1'b0;
      end
      // A half-written limit holds off the wrap flag until its partner byte lands.
      if (i_wr && i_addr == timer_pwm_pkg::ADDR_LIMIT_HIGH)
      begin
         limit_next = set_byte(limit_reg, 1'b1, i_wdata);
         lim_pend_hi_next = !lim_pend_lo_reg;
         lim_pend_lo_next = 1'b0;
      end
      if (i_wr && i_addr == timer_pwm_pkg::ADDR_LIMIT_LOW)
      begin
         limit_next = set_byte(limit_reg, 1'b0, i_wdata);
         lim_pend_lo_next = !lim_pend_hi_reg;
         lim_pend_hi_next = 1'b0;
      end
      {wrap_flag_next, wrap_arm_next} = flag_step(wrap_flag_reg, wrap_arm_reg,
         wrap_ev && !lim_pend_hi_reg && !lim_pend_lo_reg, sc_rd, sc_wr,
         i_wdata[timer_pwm_pkg::SC_FLAG_BIT]);
      if (i_rd)
      begin
         if (i_addr == timer_pwm_pkg::ADDR_STATUS_CTRL)
         begin
            rdata_next = {wrap_flag_reg, sc_reg};
         end
         else if (i_addr == timer_pwm_pkg::ADDR_COUNT_HIGH ||
                  i_addr == timer_pwm_pkg::ADDR_COUNT_LOW)
         begin
            // Reads only snapshot the count; they never touch the counter itself.
            if (!latched_reg)
            begin
               latch_next = cnt_reg;
               latched_next = 1'b1;
               latch_hi_first_next = i_addr == timer_pwm_pkg::ADDR_COUNT_HIGH;
               rdata_next = latch_hi_first_next ? cnt_reg[15:8] : cnt_reg[7:0];
            end
            else
            begin
               rdata_next = (i_addr == timer_pwm_pkg::ADDR_COUNT_HIGH)
                            ? latch_reg[15:8] : latch_reg[7:0];
               if ((i_addr == timer_pwm_pkg::ADDR_COUNT_HIGH) != latch_hi_first_reg)
               begin
                  latched_next = 1'b0;
               end
            end
         end
         else if (i_addr == timer_pwm_pkg::ADDR_LIMIT_HIGH)
         begin
            rdata_next = limit_reg[15:8];
         end
         else if (i_addr == timer_pwm_pkg::ADDR_LIMIT_LOW)
         begin
            rdata_next = limit_reg[7:0];
         end
         else if (i_addr == timer_pwm_pkg::ADDR_OPTION)
         begin
            rdata_next = {5'h00, opt_reg};
         end
         for (int i = 0; i < 2; i++)
         begin
            if (i_addr == timer_pwm_pkg::ADDR_CH_CTRL[i])
            begin
               rdata_next = ch_ctrl_reg[i] | {ch_flag_reg[i], 7'h00};
            end
            else if (i_addr == timer_pwm_pkg::ADDR_CH_VAL_HIGH[i])
            begin
               rdata_next = ch_val_reg[i][15:8];
            end
            else if (i_addr == timer_pwm_pkg::ADDR_CH_VAL_LOW[i])
            begin
               rdata_next = ch_val_reg[i][7:0];
            end
         end
      end
      wrap_irq_next = wrap_flag_next && sc_next[timer_pwm_pkg::SC_IE_BIT];
   end

   // Per-channel capture, compare, PWM and pin ownership.
   always_comb
   begin
      logic [1:0] mode;
      logic [1:0] edge_sel;
      logic src;
      logic hit;
      logic match;
      logic own;
      logic drive;
      logic pwm_level;
      mode = 2'h0;
      edge_sel = 2'h0;
      src = 1'b0;
      hit = 1'b0;
      match = 1'b0;
      own = 1'b0;
      drive = 1'b0;
      pwm_level = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         ch_ctrl_next[i] = ch_ctrl_reg[i];
         ch_val_next[i] = ch_val_reg[i];
         ch_buf_next[i] = ch_buf_reg[i];
         mode = ch_ctrl_reg[i][timer_pwm_pkg::CH_MODE_LSB +: 2];
         edge_sel = ch_ctrl_reg[i][timer_pwm_pkg::CH_EDGE_LSB +: 2];
         src = (i == 0 && opt_reg[timer_pwm_pkg::OPT_CH0_SRC_BIT]) ? slow_s2_reg
               : pin_s2_reg[i];
         cap_prev_next[i] = src;
         ch_out_next[i] = ch_out_reg[i];
         hit = 1'b0;
         match = ptick && !cnt_wr && cnt_next == ch_val_reg[i];
         pwm_level = (cnt_reg < ch_val_reg[i]) ^ edge_sel[0];
         if (center)
         begin
            ch_out_next[i] = pwm_level;
            hit = match;
         end
         else if (mode == timer_pwm_pkg::MODE_CAPTURE)
         begin
            unique case (edge_sel)
               timer_pwm_pkg::EDGE_RISE: hit = src & ~cap_prev_reg[i];
               timer_pwm_pkg::EDGE_FALL: hit = ~src & cap_prev_reg[i];
               timer_pwm_pkg::EDGE_BOTH: hit = src ^ cap_prev_reg[i];
               timer_pwm_pkg::EDGE_NONE: hit = 1'b0;
            endcase
         end
         else if (mode == timer_pwm_pkg::MODE_COMPARE)
         begin
            hit = match;
            if (match)
            begin
               unique case (edge_sel)
                  timer_pwm_pkg::ACT_TOGGLE: ch_out_next[i] = ~ch_out_reg[i];
                  timer_pwm_pkg::ACT_CLEAR: ch_out_next[i] = 1'b0;
                  timer_pwm_pkg::ACT_SET: ch_out_next[i] = 1'b1;
                  default: ch_out_next[i] = ch_out_reg[i];
               endcase
            end
         end
         else
         begin
            ch_out_next[i] = pwm_level;
            hit = match;
         end
         // Software writes land in the buffer; PWM modes load it at the period edge.
         if (i_wr && i_addr == timer_pwm_pkg::ADDR_CH_CTRL[i])
         begin
            ch_ctrl_next[i] = {1'b0, i_wdata[6:2], 2'h0};
         end
         if (i_wr && (i_addr == timer_pwm_pkg::ADDR_CH_VAL_HIGH[i] ||
                      i_addr == timer_pwm_pkg::ADDR_CH_VAL_LOW[i]))
         begin
            ch_buf_next[i] = set_byte(ch_buf_reg[i],
                                      i_addr == timer_pwm_pkg::ADDR_CH_VAL_HIGH[i], i_wdata);
            if (!center && !mode[1])
            begin
               ch_val_next[i] = ch_buf_next[i];
            end
         end
         if ((center || mode[1]) && (wrap_ev || clksel == timer_pwm_pkg::CLKSEL_OFF))
         begin
            ch_val_next[i] = ch_buf_reg[i];
         end
         if (!center && mode == timer_pwm_pkg::MODE_CAPTURE && hit)
         begin
            ch_val_next[i] = cnt_reg;
         end
         {ch_flag_next[i], ch_arm_next[i]} = flag_step(ch_flag_reg[i], ch_arm_reg[i], hit,
            i_rd && i_addr == timer_pwm_pkg::ADDR_CH_CTRL[i],
            i_wr && i_addr == timer_pwm_pkg::ADDR_CH_CTRL[i],
            i_wdata[timer_pwm_pkg::CH_FLAG_BIT]);
         ch_irq_next[i] = ch_flag_next[i] && ch_ctrl_next[i][timer_pwm_pkg::CH_IE_BIT];
         // A channel owns its pin only when its edge or action field is nonzero.
         own = edge_sel != timer_pwm_pkg::EDGE_NONE;
         drive = own && (center || mode != timer_pwm_pkg::MODE_CAPTURE);
         pin_next[i] = drive ? ch_out_reg[i] : i_gpio_data[i];
         oe_n_next[i] = drive ? 1'b0 : (own ? 1'b1 : ~i_gpio_dir[i]);
         pullup_next[i] = own && !drive && opt_reg[timer_pwm_pkg::OPT_PULLUP_LSB + i];
      end
   end

   // All state registers but the input synchronizers; reset leaves the timer off and pins as inputs.
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sc_reg <= timer_pwm_pkg::SC_RESET;
         wrap_flag_reg <= 1'b0;
         wrap_arm_reg <= 1'b0;
         cnt_reg <= timer_pwm_pkg::CNT_RESET;
         down_reg <= 1'b0;
         pre_reg <= 7'h00;
         limit_reg <= timer_pwm_pkg::LIMIT_RESET;
         lim_pend_hi_reg <= 1'b0;
         lim_pend_lo_reg <= 1'b0;
         latch_reg <= timer_pwm_pkg::CNT_RESET;
         latched_reg <= 1'b0;
         latch_hi_first_reg <= 1'b0;
         opt_reg <= timer_pwm_pkg::OPT_RESET;
         for (int i = 0; i < 2; i++)
         begin
            ch_ctrl_reg[i] <= timer_pwm_pkg::CH_CTRL_RESET;
            ch_val_reg[i] <= timer_pwm_pkg::VAL_RESET;
            ch_buf_reg[i] <= timer_pwm_pkg::VAL_RESET;
         end
         ch_flag_reg <= 2'h0;
         ch_arm_reg <= 2'h0;
         ch_out_reg <= 2'h0;
         cap_prev_reg <= 2'h0;
         rdata_reg <= 8'h00;
         pin_reg <= 2'h0;
         oe_n_reg <= 2'h3;
         pullup_reg <= 2'h0;
         wrap_irq_reg <= 1'b0;
         ch_irq_reg <= 2'h0;
      end
      else
      begin
         sc_reg <= sc_next;
         wrap_flag_reg <= wrap_flag_next;
         wrap_arm_reg <= wrap_arm_next;
         cnt_reg <= cnt_next;
         down_reg <= down_next;
         pre_reg <= pre_next;
         limit_reg <= limit_next;
         lim_pend_hi_reg <= lim_pend_hi_next;
         lim_pend_lo_reg <= lim_pend_lo_next;
         latch_reg <= latch_next;
         latched_reg <= latched_next;
         latch_hi_first_reg <= latch_hi_first_next;
         opt_reg <= opt_next;
         for (int i = 0; i < 2; i++)
         begin
            ch_ctrl_reg[i] <= ch_ctrl_next[i];
            ch_val_reg[i] <= ch_val_next[i];
            ch_buf_reg[i] <= ch_buf_next[i];
         end
         ch_flag_reg <= ch_flag_next;
         ch_arm_reg <= ch_arm_next;
         ch_out_reg <= ch_out_next;
         cap_prev_reg <= cap_prev_next;
         rdata_reg <= rdata_next;
         pin_reg <= pin_next;
         oe_n_reg <= oe_n_next;
         pullup_reg <= pullup_next;
         wrap_irq_reg <= wrap_irq_next;
         ch_irq_reg <= ch_irq_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_chan_pin = pin_reg;
   assign o_chan_pin_oe_n = oe_n_reg;
   assign o_chan_pullup = pullup_reg;
   assign o_wrap_irq = wrap_irq_reg;
   assign o_chan_irq = ch_irq_reg;

endmodule
`default_nettype wire

// ==== tb/timer_pwm_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_far_side
(
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic [1:0] i_ext,
   input wire logic [1:0] i_oe_n,
   input wire logic [1:0] i_out,
   output logic o_xtal,
   output logic o_slow,
   output logic [1:0] o_pin
);
   int n = 0;
   // Free cycle count that paces both far-side clocks.
   always @(posedge i_clk)
      n <= n + 1;
   // The 500 kHz crystal-derived clock runs only when asked to.
   assign o_xtal = i_run & (n % 200 < 100);
   assign o_slow = (n % 2000 < 1000);
   // A pin carries the timer's level while it drives, else the outside driver's.
   assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule
`default_nettype wire

// ==== tb/two_channel_timer_pwm_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_channel_timer_pwm_asserts
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [1:0] o_chan_pin_oe_n,
   input wire logic [1:0] o_chan_pullup,
   input wire logic o_wrap_irq,
   input wire logic [1:0] o_chan_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Bus answers, flag persistence, pull-up use and reset state.
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   AST_UNMAPPED: assert property (i_rd && i_addr > 4'hB |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_WRAP_HOLD: assert property (o_wrap_irq && !(i_wr && i_addr == 4'h0) |=> o_wrap_irq)
      else $error("wrap request dropped");
   AST_CH0_HOLD: assert property (o_chan_irq[0] && !(i_wr && i_addr == 4'h5) |=> o_chan_irq[0])
      else $error("channel 0 request dropped");
   AST_CH1_HOLD: assert property (o_chan_irq[1] && !(i_wr && i_addr == 4'h8) |=> o_chan_irq[1])
      else $error("channel 1 request dropped");
   AST_PULLUP_INPUT: assert property ((o_chan_pullup & ~o_chan_pin_oe_n) == 2'h0)
      else $error("pull-up on a driven pin");
   AST_RESET_PINS: assert property ($rose(i_rst_n) |-> o_chan_pin_oe_n == 2'h3 && o_chan_pullup == 2'h0)
      else $error("pins not released after reset");
   AST_RESET_IRQ: assert property ($rose(i_rst_n) |-> !o_wrap_irq && o_chan_irq == 2'h0)
      else $error("requests set after reset");
   // Main scenarios reached.
   cover property ($fell(o_wrap_irq));
   cover property (o_chan_irq[0]);
   cover property (!o_chan_pin_oe_n[1]);
endmodule
`default_nettype wire

// ==== tb/two_channel_timer_pwm_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_channel_timer_pwm_tb;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, run = 0, xtal, slow, wirq;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, rv;
   logic [1:0] ext = 2'h0, gd = 2'h0, gdir = 2'h1, pin, pout, oe_n, pu, cirq;
   logic [15:0] cv, c0;
   logic [15:0] rows [14] = '{16'h0000, 16'h0300, 16'h0500, 16'h0800, 16'h0B00, 16'h1312,
      16'h0312, 16'h155F, 16'h055C, 16'h1CAA, 16'h0C00, 16'h1B02, 16'h0B02, 16'h1300};
   int err_total = 0, n_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   two_channel_timer_pwm i_two_channel_timer_pwm (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_crystal_derived_clock(xtal),
      .i_slow_oscillator(slow), .i_chan_pin(pin), .o_chan_pin(pout), .o_chan_pin_oe_n(oe_n),
      .o_chan_pullup(pu), .i_gpio_data(gd), .i_gpio_dir(gdir), .o_wrap_irq(wirq),
      .o_chan_irq(cirq));
   timer_pwm_far_side i_timer_pwm_far_side (.i_clk(clk), .i_run(run), .i_ext(ext),
      .i_oe_n(oe_n), .i_out(pout), .o_xtal(xtal), .o_slow(slow), .o_pin(pin));
   // Bus cycles, comparison and the closing report.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdt(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rv = rdata;
   endtask
   task automatic rc();
      rdt(4'h2);
      cv[7:0] = rv;
      rdt(4'h1);
      cv[15:8] = rv;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         conclude();
      end
   end
   // Main sequence.
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i][12])
            wrt(rows[i][11:8], rows[i][7:0]);
         else
         begin
            rdt(rows[i][11:8]);
            chk(rv, rows[i][7:0]);
         end
      end
      wrt(4'h4, 8'h03);
      wrt(4'h1, 8'h00);
      wrt(4'h0, 8'h48);
      repeat (10) @(posedge clk);
      chk(wirq, 1);
      rc();
      chk(cv <= 3, 1);
      wrt(4'h0, 8'h40);
      #1;
      chk(wirq, 1);
      rdt(4'h0);
      chk(rv, 8'hC0);
      wrt(4'h0, 8'h40);
      #1;
      chk(wirq, 0);
      wrt(4'h4, 8'h00);
      for (int p = 0; p < 8; p++)
      begin
         wrt(4'h0, 8'h08 | 8'(p));
         wrt(4'h1, 8'h00);
         repeat (254) @(posedge clk);
         rc();
         chk(cv + 2 >= (256 >> p) && cv <= (256 >> p) + 2, 1);
      end
      wrt(4'h0, 8'h10);
      rc();
      c0 = cv;
      repeat (50) @(posedge clk);
      rc();
      chk(cv, c0);
      run <= 1'b1;
      wrt(4'h0, 8'h18);
      wrt(4'h1, 8'h00);
      repeat (2000) @(posedge clk);
      rc();
      chk(cv >= 9 && cv <= 11, 1);
      run <= 1'b0;
      wrt(4'h8, 8'h44);
      wrt(4'h0, 8'h08);
      wrt(4'h1, 8'h00);
      repeat (20) @(posedge clk);
      ext <= 2'h2;
      repeat (10) @(posedge clk);
      chk({cirq[1], oe_n[1]}, 2'h3);
      rdt(4'hA);
      chk(rv >= 18 && rv <= 30, 1);
      wrt(4'hB, 8'h07);
      rdt(4'h5);
      wrt(4'h5, 8'h44);
      #1;
      chk(cirq[0], 0);
      repeat (2100) if (!cirq[0]) @(posedge clk);
      chk(cirq[0], 1);
      chk(pu, 2'h3);
      wrt(4'h8, 8'h1C);
      wrt(4'h9, 8'h00);
      wrt(4'hA, 8'h20);
      wrt(4'h1, 8'h00);
      repeat (40) @(posedge clk);
      chk({pout[1], oe_n[1]}, 2'h2);
      // Center mode with a limit of 0x40: the count turns down after the top.
      wrt(4'h4, 8'h40);
      wrt(4'h3, 8'h00);
      wrt(4'h8, 8'h28);
      wrt(4'h0, 8'h28);
      wrt(4'h1, 8'h00);
      repeat (70) @(posedge clk);
      rc();
      chk(cv >= 50 && cv <= 62, 1);
      chk({pout[1], oe_n[1]}, 2'h0);
      rdt(4'h0);
      chk(rv, 8'hA8);
      rst_n <= 1'b0;
      gd <= 2'h1;
      repeat (3) @(posedge clk);
      chk({pu, oe_n}, 4'h3);
      rst_n <= 1'b1;
      rdt(4'h0);
      chk({rv, 2'h0, pout, pu, oe_n}, 16'h0012);
      conclude();
   end
endmodule
bind two_channel_timer_pwm two_channel_timer_pwm_asserts i_two_channel_timer_pwm_asserts (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_chan_pin_oe_n(o_chan_pin_oe_n), .o_chan_pullup(o_chan_pullup),
   .o_wrap_irq(o_wrap_irq), .o_chan_irq(o_chan_irq));
`default_nettype wire
